// file: design/irq_regs_pkg.sv
/*
  constants and carrier types for the interrupt enable and priority registers.
  assumes an apb master on the system clock with 32-bit data.
*/
package irq_regs_pkg;
  localparam logic [11:0] ADDR_ENABLE = 12'h000;
  localparam logic [11:0] ADDR_PRIORITY = 12'h004;
  localparam logic [15:0] ENABLE_MASK = 16'h00F6;
  localparam logic [15:0] PRIORITY_MASK = 16'h7777;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] PRIORITY_RESET = 16'h4444;
  localparam int BIT_MSG_TX_B = 7;
  localparam int BIT_MSG_TX_A = 6;
  localparam int BIT_DMA_SEVEN = 5;
  localparam int BIT_DMA_SIX = 4;
  localparam int BIT_SERIAL_B = 2;
  localparam int BIT_SERIAL_A = 1;
  localparam int LSB_TIMER_ONE = 12;
  localparam int LSB_COMPARE_ONE = 8;
  localparam int LSB_CAPTURE_ONE = 4;
  localparam int LSB_EXT_PIN_ZERO = 0;
  localparam int NUM_ENABLE_SRC = 6;
  localparam int NUM_PRIO_SRC = 4;
  localparam logic [2:0] LEVEL_OFF = 3'h0;
  localparam logic [2:0] LEVEL_TOP = 3'h7;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [15:0] enable;
    logic [15:0] prio_reg; // priority is a reserved word, so the field is named for its register
    apb_rsp_t rsp;
    logic [5:0] req_gated;
    logic [11:0] prio_out;
    logic [2:0] top_level;
  } state_t;
endpackage

// file: design/irq_enable_priority_regs.sv
/*
  enable and priority registers of the interrupt controller behind an apb slave.
  assumes request inputs are synchronous to clk_sys_i and the core consumes the
  gated requests, per-source levels and the highest pending level.
  the apb slave answers with one wait state, stretched while clk_en_i is low or the synced reset is held; an
  unmapped address answers with pslverr and leaves both registers untouched.
  every output is a flop, so the core sees gating and ranking one cycle late;
  a source that needs zero-latency masking must gate upstream instead.
  clk_en_i low freezes the registers and the bus answer alike, so a master
  must not time out on a slave that is being held.
*/
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module irq_enable_priority_regs (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire irq_regs_pkg::apb_req_t apb_i,
  output irq_regs_pkg::apb_rsp_t apb_o,
  input wire logic [5:0] src_req_i,
  input wire logic [3:0] prio_src_req_i,
  output logic [5:0] req_gated_o,
  output logic [11:0] prio_level_o,
  output logic [2:0] top_level_o
);
  irq_regs_pkg::state_t s_q;
  irq_regs_pkg::state_t s_d;
  logic [2:0] field [4];
  logic [2:0] best;
  logic wr_en;
  logic rd_hit;
  // state other than the reset sync stage may move only with the enable high and the synced reset released
  logic run;
  logic take;

  // enable bit positions in source-index order, low to high
  localparam int EN_POS [6] = '{irq_regs_pkg::BIT_SERIAL_A, irq_regs_pkg::BIT_SERIAL_B,
    irq_regs_pkg::BIT_DMA_SIX, irq_regs_pkg::BIT_DMA_SEVEN,
    irq_regs_pkg::BIT_MSG_TX_A, irq_regs_pkg::BIT_MSG_TX_B};
  localparam int PR_LSB [4] = '{irq_regs_pkg::LSB_EXT_PIN_ZERO, irq_regs_pkg::LSB_CAPTURE_ONE,
    irq_regs_pkg::LSB_COMPARE_ONE, irq_regs_pkg::LSB_TIMER_ONE};

  // priority fields sliced out per source
  for (genvar g = 0; g < irq_regs_pkg::NUM_PRIO_SRC; g++) begin : g_field
    assign field[g] = s_q.prio_reg[PR_LSB[g] +: 3];
  end

  // highest level among pending, nonzero-priority sources
  always_comb begin
    best = irq_regs_pkg::LEVEL_OFF;
    for (int i = 0; i < irq_regs_pkg::NUM_PRIO_SRC; i++) begin
      if (prio_src_req_i[i] && field[i] > best) begin
        best = field[i];
      end
    end
  end

  assign wr_en = apb_i.psel && apb_i.penable && apb_i.pwrite;
  assign rd_hit = (apb_i.paddr == irq_regs_pkg::ADDR_ENABLE) || (apb_i.paddr == irq_regs_pkg::ADDR_PRIORITY);
  // qualifiers used by the checks below; they mirror the register process gating
  assign run = clk_en_i && s_q.rst_sync[1];
  assign take = run && apb_i.psel && apb_i.penable && !s_q.rsp.pready;

  // next state: bus access, gating and output staging
  always_comb begin
    s_d = s_q;
    s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
    s_d.rsp.pready = 1'b0;
    s_d.rsp.pslverr = 1'b0;
    // one wait state: answer the cycle after the access phase starts
    if (apb_i.psel && apb_i.penable && !s_q.rsp.pready) begin
      s_d.rsp.pready = 1'b1;
      s_d.rsp.pslverr = !rd_hit;
      s_d.rsp.prdata = 32'h0000_0000;
      if (!apb_i.pwrite && apb_i.paddr == irq_regs_pkg::ADDR_ENABLE) begin
        s_d.rsp.prdata = {16'h0000, s_q.enable};
      end else if (!apb_i.pwrite && apb_i.paddr == irq_regs_pkg::ADDR_PRIORITY) begin
        s_d.rsp.prdata = {16'h0000, s_q.prio_reg};
      end
      if (wr_en && apb_i.paddr == irq_regs_pkg::ADDR_ENABLE) begin
        s_d.enable = apb_i.pwdata[15:0] & irq_regs_pkg::ENABLE_MASK;
      end
      if (wr_en && apb_i.paddr == irq_regs_pkg::ADDR_PRIORITY) begin
        // masking here keeps the reserved gaps at zero without any read-side logic
        s_d.prio_reg = apb_i.pwdata[15:0] & irq_regs_pkg::PRIORITY_MASK;
      end
    end
    for (int i = 0; i < irq_regs_pkg::NUM_ENABLE_SRC; i++) begin
      s_d.req_gated[i] = src_req_i[i] & s_q.enable[EN_POS[i]];
    end
    for (int i = 0; i < irq_regs_pkg::NUM_PRIO_SRC; i++) begin
      s_d.prio_out[i*3 +: 3] = field[i];
    end
    s_d.top_level = best;
  end

  // reset sync stage runs freely; the rest waits for the enable and synced reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.enable <= irq_regs_pkg::ENABLE_RESET;
      s_q.prio_reg <= irq_regs_pkg::PRIORITY_RESET;
    end else if (!s_q.rst_sync[1]) begin
      s_q.rst_sync <= s_d.rst_sync;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  assign apb_o = s_q.rsp;
  assign req_gated_o = s_q.req_gated;
  assign prio_level_o = s_q.prio_out;
  assign top_level_o = s_q.top_level;

  gate_block_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    clk_en_i && s_q.rst_sync[1] && !s_q.enable[irq_regs_pkg::BIT_SERIAL_A] |=> !req_gated_o[0])
    else $error("disabled source request passed");
  unused_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (s_q.enable & ~irq_regs_pkg::ENABLE_MASK) == 16'h0000
    && (s_q.prio_reg & ~irq_regs_pkg::PRIORITY_MASK) == 16'h0000)
    else $error("unimplemented bit held a one");
  top_level_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    clk_en_i && s_q.rst_sync[1] && prio_src_req_i[3] && field[3] == irq_regs_pkg::LEVEL_TOP
    |=> top_level_o == irq_regs_pkg::LEVEL_TOP)
    else $error("level 7 not ranked highest");
  zero_blocks_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    clk_en_i && s_q.rst_sync[1] && prio_src_req_i == 4'hF && s_q.prio_reg == 16'h0000
    |=> top_level_o == irq_regs_pkg::LEVEL_OFF)
    else $error("disabled priority source raised a level");
  enable_pos_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    clk_en_i && s_q.rst_sync[1] && src_req_i[5] && s_q.enable[irq_regs_pkg::BIT_MSG_TX_B]
    |=> req_gated_o[5])
    else $error("message tx b enable misplaced");
  prio_pos_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    prio_level_o[11:9] == $past(s_q.prio_reg[14:12]) || !$past(clk_en_i) || !$past(s_q.rst_sync[1]))
    else $error("timer one field misplaced");
  ready_pulse_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    apb_o.pready |=> !apb_o.pready)
    else $error("pready held two cycles");

  // bus side checks: all but the upper-half read check are qualified by take, so frozen cycles never count
  // unmapped access answers with an error and no write
  unmapped_err_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    take && !rd_hit
    |=> apb_o.pready && apb_o.pslverr && $stable(s_q.enable) && $stable(s_q.prio_reg))
    else $error("unmapped access not refused");

  // enable write keeps only the implemented bits
  enable_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    take && wr_en && apb_i.paddr == irq_regs_pkg::ADDR_ENABLE
    |=> s_q.enable == ($past(apb_i.pwdata[15:0]) & irq_regs_pkg::ENABLE_MASK))
    else $error("enable write landed wrong");

  // priority write keeps only the four fields
  prio_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    take && wr_en && apb_i.paddr == irq_regs_pkg::ADDR_PRIORITY
    |=> s_q.prio_reg == ($past(apb_i.pwdata[15:0]) & irq_regs_pkg::PRIORITY_MASK))
    else $error("priority write landed wrong");

  // upper half of every answer reads zero
  upper_read_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    apb_o.pready
    |-> apb_o.prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");

  // enable read returns the stored register
  read_enable_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    take && !apb_i.pwrite && apb_i.paddr == irq_regs_pkg::ADDR_ENABLE
    |=> apb_o.prdata == {16'h0000, $past(s_q.enable)})
    else $error("enable read returned wrong data");

  // gating and ranking checks
  // a held block keeps its gated requests, top level and enable register
  freeze_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !clk_en_i && s_q.rst_sync[1]
    |=> $stable(req_gated_o) && $stable(top_level_o) && $stable(s_q.enable))
    else $error("state moved while held");

  // an enabled serial a request passes
  serial_pass_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    run && src_req_i[0] && s_q.enable[irq_regs_pkg::BIT_SERIAL_A]
    |=> req_gated_o[0])
    else $error("enabled serial request lost");

  // a cleared message tx a enable blocks its source
  msg_a_block_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    run && !s_q.enable[irq_regs_pkg::BIT_MSG_TX_A]
    |=> !req_gated_o[4])
    else $error("disabled message request passed");

  // dma seven enable sits at its own bit
  dma_seven_pos_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    run && src_req_i[3] && s_q.enable[irq_regs_pkg::BIT_DMA_SEVEN]
    |=> req_gated_o[3])
    else $error("dma seven enable misplaced");

  // capture one field reaches its output slot
  capture_pos_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    run
    |=> prio_level_o[5:3] == $past(s_q.prio_reg[6:4]))
    else $error("capture one field misplaced");

  // a lone pending source zero reports its own binary level, zero when off
  single_level_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    run && prio_src_req_i == 4'h1
    |=> top_level_o == $past(field[0]))
    else $error("single source level not mapped");

  // nothing pending ranks as off
  none_pending_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    run && prio_src_req_i == 4'h0
    |=> top_level_o == irq_regs_pkg::LEVEL_OFF)
    else $error("level raised with nothing pending");

  // the winner is never below pending source zero
  top_not_lower_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    run && prio_src_req_i[0]
    |=> top_level_o >= $past(field[0]))
    else $error("ranking below a pending source");
endmodule // irq_enable_priority_regs

// file: bench/src_model.sv
/* partner model: peripheral sources holding level requests; assumes the bench sets the pattern at clock edges */
`timescale 1ns/1ps
module src_model (
  input wire logic clk_sys_i,
  input wire logic [9:0] want_i,
  output logic [5:0] src_req_o,
  output logic [3:0] prio_req_o
);
  // sources raise and hold levels one edge after being told, as real peripherals lag
  always_ff @(posedge clk_sys_i) begin
    {prio_req_o, src_req_o} <= want_i;
  end
endmodule // src_model

// file: bench/tb.sv
/* self-checking bench for the enable and priority registers; assumes the package and src_model come first */
`timescale 1ns/1ps
module tb;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  irq_regs_pkg::apb_req_t apb_i = '0;
  irq_regs_pkg::apb_rsp_t apb_o;
  logic [9:0] want = '0;
  logic [5:0] src, gated, exp_g;
  logic clk_en = 1'b1;
  logic [3:0] preq;
  logic [11:0] lvl;
  logic [2:0] top, tx;
  logic [15:0] rd, en, pr;
  logic err;
  int err_count = 0, num_checks = 0, seed = 58;
  irq_enable_priority_regs i_irq_enable_priority_regs (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en),
    .apb_i(apb_i), .apb_o(apb_o), .src_req_i(src), .prio_src_req_i(preq), .req_gated_o(gated),
    .prio_level_o(lvl), .top_level_o(top));
  src_model i_src_model (.clk_sys_i(clk_sys_i), .want_i(want), .src_req_o(src), .prio_req_o(preq));
  // 40 MHz clock
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input string what, input logic [15:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; pready is read before the edge's own updates land
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys_i);
    apb_i.penable <= 1'b1;
    do @(posedge clk_sys_i); while (apb_o.pready !== 1'b1);
    rd = apb_o.prdata[15:0];
    err = apb_o.pslverr;
    apb_i <= '0;
  endtask
  // highest field among pending sources, zero fields never win
  function automatic logic [2:0] top_of(input logic [15:0] p, input logic [3:0] r);
    top_of = 3'h0;
    for (int k = 0; k < 4; k++) begin
      if (r[k] && p[4*k +: 3] > top_of) begin
        top_of = p[4*k +: 3];
      end
    end
  endfunction
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    apb(1'b0, 12'h000, 32'h0);
    chk("enable reset", 16'h0000, rd);
    apb(1'b0, 12'h004, 32'h0);
    chk("priority reset", 16'h4444, rd);
    apb(1'b1, 12'h000, 32'hFFFFFFFF);
    apb(1'b0, 12'h000, 32'h0);
    chk("enable mask", 16'h00F6, rd);
    apb(1'b1, 12'h004, 32'hFFFFFFFF);
    apb(1'b0, 12'h004, 32'h0);
    chk("priority mask", 16'h7777, rd);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped", 16'h0001, {15'h0, err});
    // first eight passes set every level code in all fields
    for (int i = 0; i < 24; i++) begin
      tx = i[2:0];
      en = 16'($random(seed));
      pr = (i < 8) ? {4{1'b0, tx}} : 16'($random(seed));
      apb(1'b1, 12'h000, {16'h0, en});
      apb(1'b1, 12'h004, {16'h0, pr});
      want <= (i == 0) ? 10'h3FF : 10'($random(seed)); // all zero fields with all pending first
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk("gated", {10'h0, want[5:0] & {en[7:4], en[2:1]}}, {10'h0, gated});
      chk("levels", {4'h0, pr[14:12], pr[10:8], pr[6:4], pr[2:0]}, {4'h0, lvl});
      chk("top level", {13'h0, top_of(pr, want[9:6])}, {13'h0, top});
    end
    // hold the block: new requests must not show until released
    @(posedge clk_sys_i);
    clk_en <= 1'b0;
    exp_g = want[5:0] & {en[7:4], en[2:1]};
    want <= ~want;
    repeat (4) @(posedge clk_sys_i);
    #1;
    chk("frozen gated", {10'h0, exp_g}, {10'h0, gated});
    @(posedge clk_sys_i);
    clk_en <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk("released gated", {10'h0, want[5:0] & {en[7:4], en[2:1]}}, {10'h0, gated});
    // mid-run reset brings both registers back to their defaults
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    apb(1'b0, 12'h004, 32'h0);
    chk("priority after reset", irq_regs_pkg::PRIORITY_RESET, rd);
    apb(1'b0, 12'h000, 32'h0);
    chk("enable after reset", irq_regs_pkg::ENABLE_RESET, rd);
    test_done;
  end
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    err_count++;
    test_done;
  end
endmodule // tb
